// ===== verilog/sli_pkg.sv
// sli_pkg: constants shared by the front-panel indicator logic
// assumes a single module clock; rates derive from the clock frequency
package sli_pkg;

  // ==========================================================
  // clock and flash rates
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned SLOW_FLASH_PER_S = 4;
  localparam int unsigned FAST_FLASH_PER_S = 8;
  localparam int unsigned CONST_FLASH_PER_S = 2;
  // half period counts: one lamp toggle per half period
  localparam int unsigned SLOW_HALF_CYC = CLK_HZ / (2 * SLOW_FLASH_PER_S);
  localparam int unsigned FAST_HALF_CYC = CLK_HZ / (2 * FAST_FLASH_PER_S);
  localparam int unsigned CONST_HALF_CYC = CLK_HZ / (2 * CONST_FLASH_PER_S);

  // ==========================================================
  // power-up fault blink code
  localparam int unsigned CODE_W = 4;
  localparam int unsigned PAUSE_HALVES = 6;
  localparam int unsigned GAP_HALVES = 12;

  // ==========================================================
  // status word layout
  localparam int unsigned STATUS_WORDS = 4;
  localparam int unsigned ERR_CODE_W = 8;
  localparam logic [1:0] ERR_SLOT_RESET = 2'h0;

  // ==========================================================
  // interrupt status / mask bit positions and register offsets
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_ERR_BIT = 0;
  localparam int unsigned IRQ_WDOG_BIT = 1;
  localparam int unsigned IRQ_PUF_BIT = 2;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h00;
  localparam logic [7:0] REG_IRQ_MASK = 8'h04;
  localparam logic [7:0] REG_LAMP_STATE = 8'h08;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

  typedef enum logic [1:0] {SLI_ERR_NONE, SLI_ERR_STATUS, SLI_ERR_STOP} sli_err_t;

endpackage

// ===== verilog/sli_status_led_indicator.sv
// sli_status_led_indicator: drives seven front-panel lamps from module state
// assumes all inputs synchronous to mclk; lamps are active high, one flop each
//
// Summary of operation
// - health lamp steady while normal, flashing while an error is signalled
// - status-only error with setup lit: health lamp flashes four per second
// - stopping error: health lamp flashes eight per second
// - during error flashing, error code goes to a status word, fault bit set
// - boot mode: health and setup lamps flash together at constant rate
// - watchdog timeout: health and setup lamps flash alternately, constant rate
// - power-up fault: setup dark, health blinks two counts with a pause
// - alive lamp lit while healthy, dark if module cannot power up
// - setup lamp lit once a valid configuration has been accepted
// - program store in progress: setup lamp flashes four per second
// - RAM to EEPROM write: setup lamp flashes eight per second
// - axis lamps one and two follow servo drive enables
// - axis lamps three and four follow analog override commands
//
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/1ps
module sli_status_led_indicator (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // module state
  input wire logic bootMode,
  input wire logic watchdogTimeout,
  input wire logic powerUpFault,
  input wire logic [sli_pkg::CODE_W-1:0] faultCodeFirst,
  input wire logic [sli_pkg::CODE_W-1:0] faultCodeSecond,
  input wire logic configValid,
  input wire logic programStoreBusy,
  input wire logic eepromWriteBusy,
  input wire logic statusOnlyError,
  input wire logic stopError,
  input wire logic [sli_pkg::ERR_CODE_W-1:0] errorCode,
  input wire logic [1:0] errorSlot,
  input wire logic servoOneDriveEnabled,
  input wire logic servoTwoDriveEnabled,
  input wire logic auxThreeOverride,
  input wire logic auxFourOverride,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdData,
  // lamps
  output logic healthLamp,
  output logic aliveLamp,
  output logic setupLamp,
  output logic servo_one_drive_lamp,
  output logic servo_two_drive_lamp,
  output logic aux_three_override_lamp,
  output logic aux_four_override_lamp,
  // status words and flags
  output logic [sli_pkg::ERR_CODE_W-1:0] statusWord [sli_pkg::STATUS_WORDS],
  output logic faultPresent,
  output logic irq
);
  import sli_pkg::*;

  // ==========================================================
  // rate dividers
  logic [26:0] slowCnt, fastCnt, constCnt;
  logic slowPh, fastPh, constPh;
  logic slowTick;

  // each divider toggles its phase every half period
  always_ff @(posedge mclk) begin
    if (srst) begin
      slowCnt <= '0;
      slowPh <= 1'b0;
    end else if (slowCnt == 27'(SLOW_HALF_CYC - 1)) begin
      slowCnt <= '0;
      slowPh <= ~slowPh;
    end else begin
      slowCnt <= slowCnt + 27'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      fastCnt <= '0;
      fastPh <= 1'b0;
    end else if (fastCnt == 27'(FAST_HALF_CYC - 1)) begin
      fastCnt <= '0;
      fastPh <= ~fastPh;
    end else begin
      fastCnt <= fastCnt + 27'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      constCnt <= '0;
      constPh <= 1'b0;
    end else if (constCnt == 27'(CONST_HALF_CYC - 1)) begin
      constCnt <= '0;
      constPh <= ~constPh;
    end else begin
      constCnt <= constCnt + 27'h1;
    end
  end

  // dividers run free from reset, so a flash phase is not tied to the moment its trigger rose
  assign slowTick = (slowCnt == 27'(SLOW_HALF_CYC - 1)); // blink code steps at slow half periods

  // ==========================================================
  // power-up fault blink sequencer
  typedef enum logic [2:0] {SLI_B_IDLE, SLI_B_FIRST, SLI_B_PAUSE, SLI_B_SECOND, SLI_B_GAP} sli_blink_t;
  sli_blink_t blinkState;
  logic [CODE_W:0] blinkHalves;
  logic [4:0] waitHalves;
  logic blinkOn;

  // counts are shown as blinks; a zero code is shown as one blink so the
  // operator still sees two separate groups
  function automatic logic [CODE_W:0] halvesFor(input logic [CODE_W-1:0] code);
    logic [CODE_W-1:0] n;
    n = (code == '0) ? CODE_W'(1) : code;
    return {n, 1'b0};
  endfunction

  // first count, pause, second count, long gap, repeat
  always_ff @(posedge mclk) begin
    if (srst) begin
      blinkState <= SLI_B_IDLE;
      blinkHalves <= '0;
      waitHalves <= '0;
      blinkOn <= 1'b0;
    end else if (!powerUpFault) begin
      blinkState <= SLI_B_IDLE;
      blinkOn <= 1'b0;
    end else if (slowTick) begin
      unique case (blinkState)
        SLI_B_IDLE: begin
          blinkState <= SLI_B_FIRST;
          blinkHalves <= halvesFor(faultCodeFirst) - (CODE_W+1)'(1);
          blinkOn <= 1'b1;
        end
        SLI_B_FIRST, SLI_B_SECOND: begin
          if (blinkHalves == '0) begin
            blinkOn <= 1'b0;
            blinkState <= (blinkState == SLI_B_FIRST) ? SLI_B_PAUSE : SLI_B_GAP;
            waitHalves <= (blinkState == SLI_B_FIRST) ? 5'(PAUSE_HALVES - 1) : 5'(GAP_HALVES - 1);
          end else begin
            blinkHalves <= blinkHalves - (CODE_W+1)'(1);
            blinkOn <= ~blinkOn;
          end
        end
        SLI_B_PAUSE, SLI_B_GAP: begin
          if (waitHalves == '0) begin
            blinkState <= (blinkState == SLI_B_PAUSE) ? SLI_B_SECOND : SLI_B_FIRST;
            blinkHalves <= halvesFor((blinkState == SLI_B_PAUSE) ? faultCodeSecond : faultCodeFirst)
              - (CODE_W+1)'(1);
            blinkOn <= 1'b1;
          end else begin
            waitHalves <= waitHalves - 5'h1;
          end
        end
        // a stray state code restarts the sequence rather than freezing the lamp
        default: begin
          blinkState <= SLI_B_IDLE;
          blinkOn <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // lamp selection
  sli_err_t errKind;
  logic next_health, next_setup, next_alive;

  // stop error outranks status-only
  always_comb begin
    if (stopError) begin
      errKind = SLI_ERR_STOP;
    end else if (statusOnlyError) begin
      errKind = SLI_ERR_STATUS;
    end else begin
      errKind = SLI_ERR_NONE;
    end
  end

  // special patterns outrank operational errors
  always_comb begin
    next_alive = ~powerUpFault;
    if (bootMode) begin
      next_health = constPh;
      next_setup = constPh;
    end else if (watchdogTimeout) begin
      next_health = constPh;
      next_setup = ~constPh;
    end else if (powerUpFault) begin
      next_health = blinkOn;
      next_setup = 1'b0;
    end else begin
      unique case (errKind)
        SLI_ERR_STOP: next_health = fastPh;
        SLI_ERR_STATUS: next_health = slowPh;
        SLI_ERR_NONE: next_health = 1'b1;
        default: next_health = 1'b1; // unused kind code shows steady
      endcase
      // eeprom write is the longer-lived job, so it wins the setup lamp
      if (eepromWriteBusy) begin
        next_setup = fastPh;
      end else if (programStoreBusy) begin
        next_setup = slowPh;
      end else begin
        next_setup = configValid;
      end
    end
  end

  // every lamp is registered so no glitch reaches the panel
  always_ff @(posedge mclk) begin
    if (srst) begin
      healthLamp <= 1'b0;
      setupLamp <= 1'b0;
      aliveLamp <= 1'b0;
    end else begin
      healthLamp <= next_health;
      setupLamp <= next_setup;
      aliveLamp <= next_alive;
    end
  end

  // axis lamps track their enables and override commands one cycle late
  always_ff @(posedge mclk) begin
    if (srst) begin
      servo_one_drive_lamp <= 1'b0;
      servo_two_drive_lamp <= 1'b0;
      aux_three_override_lamp <= 1'b0;
      aux_four_override_lamp <= 1'b0;
    end else begin
      servo_one_drive_lamp <= servoOneDriveEnabled;
      servo_two_drive_lamp <= servoTwoDriveEnabled;
      aux_three_override_lamp <= auxThreeOverride;
      aux_four_override_lamp <= auxFourOverride;
    end
  end

  // ==========================================================
  // error status words
  logic errShown;
  assign errShown = (errKind != SLI_ERR_NONE) && !bootMode && !watchdogTimeout && !powerUpFault;

  // code lands in the chosen word while the error flashes
  always_ff @(posedge mclk) begin
    if (srst) begin
      faultPresent <= 1'b0;
      for (int i = 0; i < STATUS_WORDS; i++) begin
        statusWord[i] <= '0;
      end
    end else begin
      faultPresent <= errShown;
      for (int i = 0; i < STATUS_WORDS; i++) begin
        if (errShown && errorSlot == 2'(i)) begin
          statusWord[i] <= errorCode;
        end else if (!errShown) begin
          statusWord[i] <= '0;
        end
      end
    end
  end

  // ==========================================================
  // interrupts and register port
  logic [IRQ_W-1:0] irqStatus, irqMask, evt;
  logic errShownD, wdogD, pufD;

  // one cycle of history for the event edge detectors
  always_ff @(posedge mclk) begin
    if (srst) begin
      errShownD <= 1'b0;
      wdogD <= 1'b0;
      pufD <= 1'b0;
    end else begin
      errShownD <= errShown;
      wdogD <= watchdogTimeout;
      pufD <= powerUpFault;
    end
  end

  // rising edges only, so a held condition raises its status bit once
  always_comb begin
    evt = '0;
    evt[IRQ_ERR_BIT] = errShown & ~errShownD;
    evt[IRQ_WDOG_BIT] = watchdogTimeout & ~wdogD;
    evt[IRQ_PUF_BIT] = powerUpFault & ~pufD;
  end

  // read clears status; a new event in the same cycle still sets
  always_ff @(posedge mclk) begin
    if (srst) begin
      irqStatus <= '0;
    end else if (regRead && regAddr == REG_IRQ_STATUS) begin
      irqStatus <= evt;
    end else begin
      irqStatus <= irqStatus | evt;
    end
  end

  // a mask write lands next cycle; irq follows it one cycle later
  always_ff @(posedge mclk) begin
    if (srst) begin
      irqMask <= IRQ_MASK_RESET;
    end else if (regWrite && regAddr == REG_IRQ_MASK) begin
      irqMask <= regWrData[IRQ_W-1:0];
    end
  end

  // irq registered from the updated status view
  always_ff @(posedge mclk) begin
    if (srst) begin
      irq <= 1'b0;
    end else if (regRead && regAddr == REG_IRQ_STATUS) begin
      irq <= |(evt & irqMask);
    end else begin
      irq <= |((irqStatus | evt) & irqMask);
    end
  end

  // read data valid the cycle after the strobe; unmapped reads zero
  always_ff @(posedge mclk) begin
    if (srst) begin
      regRdData <= '0;
    end else if (regRead) begin
      unique case (regAddr)
        REG_IRQ_STATUS: regRdData <= {29'h0, irqStatus};
        REG_IRQ_MASK: regRdData <= {29'h0, irqMask};
        REG_LAMP_STATE: regRdData <= {25'h0, aux_four_override_lamp, aux_three_override_lamp,
          servo_two_drive_lamp, servo_one_drive_lamp, setupLamp, aliveLamp, healthLamp};
        default: regRdData <= '0;
      endcase
    end else begin
      regRdData <= '0;
    end
  end

endmodule

// ===== tb/sli_lamp_assertions.sv
// checker: lamp and flag relations at the indicator ports
// assumes one clock domain, bound onto the indicator top
`timescale 1ns/1ps
module sli_lamp_assertions (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // module state
  input wire logic bootMode,
  input wire logic watchdogTimeout,
  input wire logic powerUpFault,
  input wire logic statusOnlyError,
  input wire logic stopError,
  input wire logic configValid,
  input wire logic programStoreBusy,
  input wire logic eepromWriteBusy,
  input wire logic [sli_pkg::ERR_CODE_W-1:0] errorCode,
  input wire logic [1:0] errorSlot,
  input wire logic servoOneDriveEnabled,
  input wire logic auxFourOverride,
  input wire logic regRead,
  // outputs
  input wire logic [31:0] regRdData,
  input wire logic healthLamp,
  input wire logic aliveLamp,
  input wire logic setupLamp,
  input wire logic servo_one_drive_lamp,
  input wire logic aux_four_override_lamp,
  input wire logic [sli_pkg::ERR_CODE_W-1:0] statusWord [sli_pkg::STATUS_WORDS],
  input wire logic faultPresent
);
  import sli_pkg::*;
  // ==========================================
  // pattern selection
  logic upper;
  logic anyErr;
  // boot, watchdog and power-up patterns hide any error flashing
  assign upper = bootMode | watchdogTimeout | powerUpFault;
  assign anyErr = stopError | statusOnlyError;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // ==========================================
  // assertions
  a_normal_steady: assert property (!$past(srst) && $past(!upper && !anyErr) |-> healthLamp)
    else $error("health lamp not steady");
  a_error_word: assert property (
    !$past(srst) && $past(anyErr && !upper) |-> faultPresent && statusWord[$past(errorSlot)] == $past(errorCode))
    else $error("error word or flag wrong");
  a_pattern_hides: assert property (!$past(srst) && $past(upper) |-> !faultPresent)
    else $error("error shown under pattern");
  a_boot_together: assert property (!$past(srst) && $past(bootMode) |-> healthLamp == setupLamp)
    else $error("boot lamps apart");
  a_wdog_apart: assert property (
    !$past(srst) && $past(watchdogTimeout && !bootMode) |-> healthLamp != setupLamp)
    else $error("watchdog lamps together");
  a_fault_setup_dark: assert property (
    !$past(srst) && $past(powerUpFault && !bootMode && !watchdogTimeout) |-> !setupLamp)
    else $error("setup lit in fault");
  a_setup_config: assert property (
    !$past(srst) && $past(!upper && !programStoreBusy && !eepromWriteBusy) |-> setupLamp == $past(configValid))
    else $error("setup lamp not following configuration");
  a_alive_follow: assert property (!$past(srst) |-> aliveLamp == !$past(powerUpFault))
    else $error("alive lamp wrong");
  a_axis_one: assert property (!$past(srst) |-> servo_one_drive_lamp == $past(servoOneDriveEnabled))
    else $error("axis one lamp wrong");
  a_aux_four: assert property (!$past(srst) |-> aux_four_override_lamp == $past(auxFourOverride))
    else $error("aux four lamp wrong");
  a_read_idle: assert property (!$past(srst) && !$past(regRead) |-> regRdData == 32'h0)
    else $error("read data not idle");
endmodule
bind sli_status_led_indicator sli_lamp_assertions chk (.mclk(mclk), .srst(srst), .bootMode(bootMode),
  .watchdogTimeout(watchdogTimeout), .powerUpFault(powerUpFault), .statusOnlyError(statusOnlyError),
  .stopError(stopError), .errorCode(errorCode), .errorSlot(errorSlot), .regRead(regRead),
  .configValid(configValid), .programStoreBusy(programStoreBusy), .eepromWriteBusy(eepromWriteBusy),
  .servoOneDriveEnabled(servoOneDriveEnabled), .auxFourOverride(auxFourOverride), .regRdData(regRdData),
  .healthLamp(healthLamp), .aliveLamp(aliveLamp), .setupLamp(setupLamp), .statusWord(statusWord),
  .servo_one_drive_lamp(servo_one_drive_lamp), .aux_four_override_lamp(aux_four_override_lamp),
  .faultPresent(faultPresent));

// ===== tb/sli_lamp_observer.sv
// observer: the operator in front of the panel
// assumes lamps change only on mclk edges
`timescale 1ns/1ps
module sli_lamp_observer (
  // clock and lamps
  input wire logic mclk,
  input wire logic healthLamp,
  // changes seen so far
  output int healthEdges
);
  logic lastHealth = 1'b0;
  initial healthEdges = 0;
  // an eye sees changes, not levels; counts every flip of the lamp
  always @(posedge mclk) begin
    lastHealth <= healthLamp;
    if (healthLamp !== lastHealth) begin
      healthEdges <= healthEdges + 1;
    end
  end
endmodule

// ===== tb/status_led_indicator_tb.sv
// testbench: indicator lamps, flags and registers against a bench model
// assumes flash half periods far longer than the run, so phases stay low
`timescale 1ns/1ps
module status_led_indicator_tb;
  import sli_pkg::*;
  logic mclk, srst, bootMode, watchdogTimeout, powerUpFault, configValid;
  logic programStoreBusy, eepromWriteBusy, statusOnlyError, stopError, regWrite, regRead, irq, faultPresent;
  logic [CODE_W-1:0] codeA, codeB;
  logic [ERR_CODE_W-1:0] errorCode;
  logic [ERR_CODE_W-1:0] statusWord [STATUS_WORDS];
  logic [1:0] errorSlot;
  logic [3:0] axis;
  logic [6:0] lamps;
  logic [7:0] regAddr;
  logic [31:0] regWrData, regRdData;
  int err_total = 0, checks = 0, seed = 55, hEdges, h0, i;
  // bench copy of the status words
  int mWord [STATUS_WORDS] = '{default: 0};
  sli_status_led_indicator uut (.mclk(mclk), .srst(srst), .bootMode(bootMode), .watchdogTimeout(watchdogTimeout),
    .powerUpFault(powerUpFault), .faultCodeFirst(codeA), .faultCodeSecond(codeB), .configValid(configValid),
    .programStoreBusy(programStoreBusy), .eepromWriteBusy(eepromWriteBusy), .statusOnlyError(statusOnlyError),
    .stopError(stopError), .errorCode(errorCode), .errorSlot(errorSlot), .servoOneDriveEnabled(axis[0]),
    .servoTwoDriveEnabled(axis[1]), .auxThreeOverride(axis[2]), .auxFourOverride(axis[3]), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .healthLamp(lamps[0]), .aliveLamp(lamps[1]), .setupLamp(lamps[2]), .servo_one_drive_lamp(lamps[3]),
    .servo_two_drive_lamp(lamps[4]), .aux_three_override_lamp(lamps[5]), .aux_four_override_lamp(lamps[6]),
    .statusWord(statusWord), .faultPresent(faultPresent), .irq(irq));
  sli_lamp_observer eye (.mclk(mclk), .healthLamp(lamps[0]), .healthEdges(hEdges));
  // ==========================================
  // shared tasks
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // two edges: one samples the inputs into lamps, flags and irq, one spare
  task automatic settle;
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask
  task automatic cmp_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRead <= 1'b0;
    #1;
    cmp(regRdData, exp);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ==========================================
  // clock and watchdog
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    #200_000;
    err_total++;
    stop_test();
  end
  // ==========================================
  // scenarios
  initial begin
    {srst, bootMode, watchdogTimeout, powerUpFault, configValid} = 5'h10;
    {programStoreBusy, eepromWriteBusy, statusOnlyError, stopError, regWrite, regRead} = 6'h0;
    {codeA, codeB, errorCode, errorSlot, axis, regAddr, regWrData} = '0;
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    configValid <= 1'b1;
    settle();
    h0 = hEdges;
    for (i = 0; i < 8; i++) begin
      @(posedge mclk);
      axis <= 4'($random(seed));
      settle();
      cmp({25'h0, lamps}, {25'h0, axis, 3'h7});
      cmp_reg(REG_LAMP_STATE, {25'h0, axis, 3'h7});
    end
    cmp(32'(hEdges - h0), 32'h0);
    $display("normal lamps done");
    for (i = 0; i < 2; i++) begin
      @(posedge mclk);
      errorCode <= 8'($random(seed));
      errorSlot <= 2'($random(seed));
      statusOnlyError <= (i == 0);
      stopError <= (i == 1);
      settle();
      cmp({31'h0, faultPresent}, 32'h1);
      cmp({24'h0, statusWord[errorSlot]}, {24'h0, errorCode});
      // words not chosen keep whatever code they last held
      mWord[errorSlot] = int'(errorCode);
      for (int k = 0; k < STATUS_WORDS; k++) begin
        cmp({24'h0, statusWord[k]}, 32'(mWord[k]));
      end
      cmp({31'h0, lamps[0]}, 32'h0);
    end
    $display("error flashing done");
    // status holds only the error rise; mask starts closed
    cmp_reg(REG_IRQ_STATUS, 32'h1);
    cmp({31'h0, irq}, 32'h0);
    cmp_reg(REG_IRQ_MASK, {29'h0, IRQ_MASK_RESET});
    wr(REG_IRQ_MASK, 32'h1);
    @(posedge mclk);
    stopError <= 1'b0;
    settle();
    cmp({31'h0, faultPresent}, 32'h0);
    cmp({statusWord[0], statusWord[1], statusWord[2], statusWord[3]}, 32'h0);
    cmp({31'h0, lamps[0]}, 32'h1);
    @(posedge mclk);
    stopError <= 1'b1;
    settle();
    cmp({31'h0, irq}, 32'h1);
    cmp_reg(REG_IRQ_STATUS, 32'h1);
    settle();
    cmp({31'h0, irq}, 32'h0);
    cmp_reg(8'h0c, 32'h0);
    wr(8'h0c, 32'hffffffff);
    cmp_reg(REG_IRQ_MASK, 32'h1);
    $display("interrupt done");
    // flash phases stay low for the whole run, so busy jobs show a dark setup lamp
    @(posedge mclk);
    programStoreBusy <= 1'b1;
    settle();
    cmp({31'h0, lamps[2]}, 32'h0);
    @(posedge mclk);
    eepromWriteBusy <= 1'b1;
    settle();
    cmp({31'h0, lamps[2]}, 32'h0);
    @(posedge mclk);
    programStoreBusy <= 1'b0;
    eepromWriteBusy <= 1'b0;
    configValid <= 1'b0;
    settle();
    cmp({31'h0, lamps[2]}, 32'h0);
    @(posedge mclk);
    configValid <= 1'b1;
    settle();
    cmp({31'h0, lamps[2]}, 32'h1);
    $display("setup lamp done");
    @(posedge mclk);
    bootMode <= 1'b1;
    settle();
    cmp({30'h0, lamps[2], lamps[0]}, 32'h0);
    cmp({31'h0, faultPresent}, 32'h0);
    @(posedge mclk);
    bootMode <= 1'b0;
    stopError <= 1'b0;
    watchdogTimeout <= 1'b1;
    settle();
    cmp({30'h0, lamps[2], lamps[0]}, 32'h2);
    @(posedge mclk);
    watchdogTimeout <= 1'b0;
    powerUpFault <= 1'b1;
    codeA <= 4'($random(seed));
    codeB <= 4'($random(seed));
    settle();
    cmp({30'h0, lamps[2:1]}, 32'h0);
    cmp_reg(REG_IRQ_STATUS, 32'h6);
    cmp({31'h0, irq}, 32'h0);
    @(posedge mclk);
    powerUpFault <= 1'b0;
    settle();
    cmp({31'h0, lamps[1]}, 32'h1);
    $display("patterns done");
    stop_test();
  end
endmodule
